// file: verilog/tdsg_regs.svh
`ifndef TDSG_REGS_SVH
`define TDSG_REGS_SVH
// reset value of the done flag
`define TDSG_DONE_RST 1'b0
// number of stages in an input synchroniser
`define TDSG_SYNC_STAGES 3
`endif

// file: verilog/tdsg_pkg.sv
package tdsg_pkg;
   // which kind of transaction is running, latched when it starts
   typedef enum logic [1:0] {
      XFER_IDLE = 2'b00,
      XFER_READ = 2'b01,
      XFER_WRITE = 2'b10,
      XFER_BUSY_CMD = 2'b11
   } tdsg_xfer_t;
endpackage

// file: verilog/tdsg_fall_det.sv
`timescale 1ns/1ps
// falling-edge detector; the input comes from logic on the same clock
module tdsg_fall_det (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_lvl,
   output logic o_fall
);
   typedef struct packed {
      logic lvl_r;
   } tdsg_fd_t;
   tdsg_fd_t st_r, st_nxt;

   // remember the previous level
   always_comb begin
      st_nxt = st_r;
      st_nxt.lvl_r = i_lvl;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_fall = st_r.lvl_r & ~i_lvl;
endmodule // tdsg_fall_det

// file: verilog/tdsg_done_gen.sv
`timescale 1ns/1ps
`include "tdsg_regs.svh"

module tdsg_done_gen (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   // activity states from the controller core
   input wire logic i_READ_XFER_ACTIVE,
   input wire logic i_DATA_LINES_IN_USE,
   input wire logic i_CMD_BLOCK_ON_DATA_LINES,
   input wire logic i_IS_WRITE,
   input wire logic i_BUSY_CMD,
   input wire logic i_HALT_AT_BOUNDARY_REQ,
   input wire logic i_TUNING_EXEC,
   // dma completion gate, tie high when no dma
   input wire logic i_DMA_DONE_OK,
   // software clear, write-one strobe
   input wire logic i_CLR_WR,
   input wire logic i_CLR_DATA,
   // status
   output logic o_XFER_DONE,
   output logic o_GAP_STOP
);
   import tdsg_pkg::*;

   typedef struct packed {
      tdsg_xfer_t kind;
      logic pend;
      logic pend_gap;
      logic done;
      logic gap;
   } tdsg_st_t;
   tdsg_st_t st_r, st_nxt;

   logic read_fall;
   logic dat_fall;
   logic inhibit_fall;
   logic evt;

   logic [2:0] lvl_vec;
   logic [2:0] fall_vec;
   logic set_now;

   // write-one decode, shared by the clear path and its checks
   function automatic logic clr_one(input logic wr, input logic data);
      return wr & data;
   endfunction

   // a pending end becomes the flag only with the dma gate open and no tuning
   function automatic logic set_fires(input logic pend, input logic dma_ok, input logic tune);
      return pend & dma_ok & ~tune;
   endfunction

   // one falling-edge detector per activity level; all same clock, no sync needed
   assign lvl_vec = {i_CMD_BLOCK_ON_DATA_LINES, i_DATA_LINES_IN_USE, i_READ_XFER_ACTIVE};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_fall
         tdsg_fall_det u_fall (
            .i_clk(I_CLK_SYS),
            .i_nrst(I_NRST),
            .i_lvl(lvl_vec[g]),
            .o_fall(fall_vec[g])
         );
      end
   endgenerate

   // name the detector outputs by what they end
   assign read_fall = fall_vec[0];
   assign dat_fall = fall_vec[1];
   assign inhibit_fall = fall_vec[2];
   assign set_now = set_fires(st_r.pend, i_DMA_DONE_OK, i_TUNING_EXEC);

   // end event per kind; read uses read-active, write uses data lines, busy uses data lines or inhibit
   always_comb begin
      st_nxt = st_r;
      evt = 1'b0;
      if (i_READ_XFER_ACTIVE && !i_IS_WRITE) begin
         st_nxt.kind = XFER_READ;
      end else if (i_DATA_LINES_IN_USE && i_IS_WRITE && st_r.kind != XFER_READ) begin
         st_nxt.kind = XFER_WRITE;
      end else if (i_DATA_LINES_IN_USE && i_BUSY_CMD && st_r.kind == XFER_IDLE) begin
         st_nxt.kind = XFER_BUSY_CMD;
      end
      case (st_r.kind)
         XFER_READ: evt = read_fall;
         XFER_WRITE: evt = dat_fall;
         XFER_BUSY_CMD: evt = dat_fall | inhibit_fall;
         default: evt = 1'b0;
      endcase
      if (evt) begin
         st_nxt.pend = 1'b1;
         // halt request present at the end means stopped at the gap
         st_nxt.pend_gap = i_HALT_AT_BOUNDARY_REQ;
         st_nxt.kind = XFER_IDLE;
      end
      // dma may hold the set back until its last beat lands
      if (st_r.pend && i_DMA_DONE_OK) begin
         st_nxt.pend = 1'b0;
         if (!i_TUNING_EXEC) begin
            st_nxt.done = 1'b1;
            st_nxt.gap = st_r.pend_gap;
         end
      end
      // clear by writing one; a set in the same cycle wins
      // set wins over a clear in the same cycle, so software never loses an end
      if (clr_one(i_CLR_WR, i_CLR_DATA) && !set_now) begin
         st_nxt.done = 1'b0;
         st_nxt.gap = 1'b0;
      end
      if (i_TUNING_EXEC) begin
         st_nxt.pend = 1'b0; // tuning blocks never produce a done
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_NRST) begin
         st_r <= '{kind: XFER_IDLE, pend: 1'b0, pend_gap: 1'b0,
                   done: `TDSG_DONE_RST, gap: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_XFER_DONE = st_r.done;
   assign o_GAP_STOP = st_r.gap;

   sequence s_read_end;
      st_r.kind == XFER_READ && read_fall && i_DMA_DONE_OK && !i_TUNING_EXEC;
   endsequence

   property p_read_set;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      s_read_end ##1 (i_DMA_DONE_OK && !i_TUNING_EXEC) |=> o_XFER_DONE;
   endproperty
   a_read_set: assert property (p_read_set) else $error("read end did not set done");

   property p_tune;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (i_TUNING_EXEC && !o_XFER_DONE) |=> !o_XFER_DONE;
   endproperty
   a_tune: assert property (p_tune) else $error("done set during tuning");

   property p_hold;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (o_XFER_DONE && !clr_one(i_CLR_WR, i_CLR_DATA)) |=> o_XFER_DONE;
   endproperty
   a_hold: assert property (p_hold) else $error("done dropped without clear");

   property p_clear;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (clr_one(i_CLR_WR, i_CLR_DATA) && !st_r.pend) |=> !o_XFER_DONE;
   endproperty
   a_clear: assert property (p_clear) else $error("write one did not clear");

   property p_no_cause;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (!o_XFER_DONE && !st_r.pend) |=> !o_XFER_DONE;
   endproperty
   a_no_cause: assert property (p_no_cause) else $error("done set without end");

   // the cycle after an end: gate open and no tuning lets the pending end through
   sequence s_gate_open;
      i_DMA_DONE_OK && !i_TUNING_EXEC;
   endsequence

   // tuning at the end cycle drops the pending end, so it is excluded here
   sequence s_write_end;
      st_r.kind == XFER_WRITE && dat_fall && !i_TUNING_EXEC;
   endsequence

   sequence s_busy_end;
      st_r.kind == XFER_BUSY_CMD && (dat_fall || inhibit_fall) && !i_TUNING_EXEC;
   endsequence

   // any end with or without a halt request standing
   sequence s_halt_end;
      evt && !i_TUNING_EXEC && i_HALT_AT_BOUNDARY_REQ;
   endsequence

   sequence s_plain_end;
      evt && !i_TUNING_EXEC && !i_HALT_AT_BOUNDARY_REQ;
   endsequence

   property p_write_set;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      s_write_end ##1 s_gate_open |=> o_XFER_DONE;
   endproperty
   a_write_set: assert property (p_write_set) else $error("write end did not set");

   property p_busy_set;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      s_busy_end ##1 s_gate_open |=> o_XFER_DONE;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy end did not set");

   // gap may rise while done already stands from an uncleared earlier end
   property p_gap;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      $rose(o_GAP_STOP) |-> o_XFER_DONE;
   endproperty
   a_gap: assert property (p_gap) else $error("gap stop without done");

   property p_set_latency;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      set_fires(st_r.pend, i_DMA_DONE_OK, i_TUNING_EXEC) |=> o_XFER_DONE;
   endproperty
   a_set_latency: assert property (p_set_latency) else $error("pending end not set");

   property p_dma_wait;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (st_r.pend && !i_DMA_DONE_OK && !o_XFER_DONE) |=> !o_XFER_DONE;
   endproperty
   a_dma_wait: assert property (p_dma_wait) else $error("done set with dma gate shut");

   property p_tune_drop;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      i_TUNING_EXEC |=> !st_r.pend;
   endproperty
   a_tune_drop: assert property (p_tune_drop) else $error("end kept during tuning");

   property p_set_wins;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (set_fires(st_r.pend, i_DMA_DONE_OK, i_TUNING_EXEC) && clr_one(i_CLR_WR, i_CLR_DATA))
         |=> o_XFER_DONE;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

   property p_gap_clear;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      (clr_one(i_CLR_WR, i_CLR_DATA) && !st_r.pend) |=> !o_GAP_STOP;
   endproperty
   a_gap_clear: assert property (p_gap_clear) else $error("gap stop not cleared");

   property p_gap_halt;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      s_halt_end ##1 s_gate_open |=> o_GAP_STOP;
   endproperty
   a_gap_halt: assert property (p_gap_halt) else $error("halt end gave no gap stop");

   property p_gap_plain;
      @(posedge I_CLK_SYS) disable iff (!I_NRST)
      s_plain_end ##1 s_gate_open |=> !o_GAP_STOP;
   endproperty
   a_gap_plain: assert property (p_gap_plain) else $error("gap stop without halt");
endmodule // tdsg_done_gen

// file: sim/tdsg_card_model.sv
`timescale 1ns/1ps
// card side: keeps activity levels up for len edges, then releases them
module tdsg_card_model
import tdsg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_go,
   input wire tdsg_pkg::tdsg_xfer_t i_kind,
   input wire logic [3:0] i_len,
   output logic o_rd,
   output logic o_dl,
   output logic o_inh
);
   logic [3:0] cnt_r = 4'h0;
   // count down the data phase; every level drops at once when the count reaches zero
   always @(posedge i_clk) begin
      if (i_go) begin
         cnt_r <= i_len;
      end else if (cnt_r != 4'h0) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
   assign o_rd = (cnt_r != 4'h0) && (i_kind == XFER_READ);
   assign o_dl = (cnt_r != 4'h0) && (i_kind != XFER_READ);
   assign o_inh = (cnt_r != 4'h0) && (i_kind == XFER_BUSY_CMD);
endmodule // tdsg_card_model

// file: sim/test_transfer_done_status_gen.sv
`timescale 1ns/1ps
module test_transfer_done_status_gen;
   import tdsg_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, go = 1'b0, halt = 1'b0, tune = 1'b0, cw = 1'b0, cd = 1'b0;
   logic rd, dl, inh, done, gap;
   logic dma = 1'b1;
   tdsg_xfer_t kind = XFER_IDLE;
   logic [3:0] len = 4'h1;
   int err_total = 0, comparisons = 0, seed = 32'h4521;
   always #12.5 clk = ~clk;
   tdsg_card_model i_card (.i_clk(clk), .i_go(go), .i_kind(kind), .i_len(len),
      .o_rd(rd), .o_dl(dl), .o_inh(inh));
   tdsg_done_gen i_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .i_READ_XFER_ACTIVE(rd),
      .i_DATA_LINES_IN_USE(dl), .i_CMD_BLOCK_ON_DATA_LINES(inh),
      .i_IS_WRITE(kind == XFER_WRITE), .i_BUSY_CMD(kind == XFER_BUSY_CMD),
      .i_HALT_AT_BOUNDARY_REQ(halt), .i_TUNING_EXEC(tune), .i_DMA_DONE_OK(dma),
      .i_CLR_WR(cw), .i_CLR_DATA(cd), .o_XFER_DONE(done), .o_GAP_STOP(gap));
   task automatic chk(string nm, logic seen, logic exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one transfer, then a refused clear and a real clear; with w nonzero the dma gate stays shut from the start until w cycles past the end
   task automatic xfer(tdsg_xfer_t k, logic [3:0] n, logic h, logic t, logic [1:0] w);
      @(negedge clk);
      kind = k;
      {len, halt, tune, go, dma} = {n, h, t, 1'b1, w == 2'h0};
      @(negedge clk);
      go = 1'b0;
      for (int i = 0; i < 20 && (rd || dl); i++) @(negedge clk);
      // lines low here; detector sees it next edge, flag one edge later
      @(negedge clk);
      chk("done_early", done, 1'b0);
      repeat (w) @(negedge clk);
      chk("done_dma_wait", done, 1'b0);
      // a clear landing with the dma release must lose to the set
      {dma, cw, cd} = {1'b1, w[1], w[1]};
      @(negedge clk);
      chk("done", done, ~t);
      chk("gap", gap, h & ~t);
      {cw, cd} = 2'b10;
      @(negedge clk);
      chk("done_keep", done, ~t);
      cd = 1'b1;
      @(negedge clk);
      chk("done_clr", done, 1'b0);
      chk("gap_clr", gap, 1'b0);
      {cw, cd, halt, tune} = 4'h0;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      chk("done_rst", done, 1'b0);
      // every kind: short with halt, long under tuning, dma-held with a racing clear
      for (int k = 1; k < 4; k++) begin
         xfer(tdsg_xfer_t'(k), 4'h1, 1'b1, 1'b0, 2'h0);
         xfer(tdsg_xfer_t'(k), 4'hF, 1'b0, 1'b1, 2'h0);
         xfer(tdsg_xfer_t'(k), 4'h3, 1'b1, 1'b0, 2'h3);
      end
      repeat (12) xfer(tdsg_xfer_t'(2'h1 + {$random(seed)} % 3), 4'h1 + 4'({$random(seed)} % 15),
         1'($random(seed)), 1'($random(seed)), 2'($random(seed)));
      // reset in mid-run with the flag set; it drops and stays down after release
      @(negedge clk);
      kind = XFER_READ;
      {len, go} = {4'h1, 1'b1};
      @(negedge clk);
      go = 1'b0;
      repeat (3) @(negedge clk);
      chk("done_pre_rst", done, 1'b1);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      chk("done_in_rst", done, 1'b0);
      chk("gap_in_rst", gap, 1'b0);
      nrst = 1'b1;
      @(negedge clk);
      chk("done_after_rst", done, 1'b0);
      xfer(XFER_WRITE, 4'h2, 1'b1, 1'b0, 2'h1);
      report_and_stop();
   end
   // watchdog well past the expected run
   initial begin
      #50000;
      err_total++;
      report_and_stop();
   end
endmodule // test_transfer_done_status_gen
